// *** srs_pkg.sv ***
// Purpose: Shared constants and types for the supply reset supervisor.
// Assumes: 50 MHz clock_i; supply_low_i and rst_line_i asynchronous.
// Notes:   Times kept in their own unit, cycle counts derived.
package srs_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int SRS_CLK_HZ = 50000000;
    localparam int SRS_HOLD_MS = 100;
    localparam int SRS_BUTTON_NS = 1500;
    localparam int SRS_DIP_US = 20;
    // Least times round up
    localparam int SRS_HOLD_CYC = SRS_HOLD_MS * (SRS_CLK_HZ / 1000);
    localparam int SRS_BUTTON_CYC =
        (SRS_BUTTON_NS * (SRS_CLK_HZ / 1000000) + 999) / 1000;
    localparam int SRS_DIP_CYC = SRS_DIP_US * (SRS_CLK_HZ / 1000000);
    localparam int SRS_CNT_W = 24;
    localparam int SRS_FLT_W = 12;

    // ==========================================================
    // Output options
    // ==========================================================
    localparam logic SRS_OUT_ACTIVE_HIGH = 1'b0;
    localparam logic SRS_OUT_OPEN_DRAIN = 1'b1;
    localparam logic SRS_MANUAL_DETECT = 1'b1;

    // Reset-cause flags carried together
    typedef struct packed {
        logic supply_low;
        logic line_low;
    } srs_cause_t;

    typedef enum logic [1:0] {
        SRS_ST_LOW = 2'b00,
        SRS_ST_HOLD = 2'b01,
        SRS_ST_RUN = 2'b10
    } srs_state_t;
endpackage : srs_pkg

// *** srs_filter.sv ***
// Purpose: Two-stage synchroniser plus persistence filter on one level.
// Assumes: Single clock domain.
// Notes:   Output asserts only after level holds QUAL_CYC cycles.
`timescale 1ns/1ns
module srs_filter #(
    parameter int W = 12,
    parameter int QUAL_CYC = 1000
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Level in and filtered out
    input wire logic level_i,
    output logic qual_o
);
    logic sync_a;
    logic sync_b;
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_qual;

    // ==========================================================
    // Next values
    // ==========================================================
    always_comb begin
        next_count = count;
        next_qual = qual_o;
        if (!sync_b) begin
            next_count = '0; // Drop below: restart qualification
            next_qual = 1'b0;
        end else if (count >= W'(QUAL_CYC - 1)) begin
            next_qual = 1'b1;
        end else begin
            next_count = count + W'(1);
        end
    end

    // Registers; sync_a feeds only sync_b
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            count <= '0;
            qual_o <= 1'b0;
        end else begin
            sync_a <= level_i;
            sync_b <= sync_a;
            count <= next_count;
            qual_o <= next_qual;
        end
    end
endmodule : srs_filter

// *** srs_supervisor.sv ***
// Purpose: Supervisory reset sequencer with hold timer and manual detect.
// Assumes: supply_low_i comes from an analog comparator, held high while
//          the supply is below the trip threshold; clock_i is internal.
// Notes:   Output enable of the shared line is low while driving low.
`timescale 1ns/1ns
// Operation
// - Assert reset while supply is reported below trip threshold.
// - After power-up recovery hold reset a full hold period, then release.
// - Every reset assertion lasts at least one whole hold period.
// - Supply dropping low clears the hold timer completely.
// - Hold timer counts only once supply is back; reset stays asserted.
// - External rising edge after qualified low starts full hold period.
// - External line held low past minimum duration asserts reset.
// - After manual release, release reset only after the hold delay.
// - Debounce the line so bounces give one reset after last release.
// - Either party may pull the shared open-drain line low.
// - Ignore short supply dips below threshold.
// - Reset output holds a correct state down to minimum supply.
// - Below the minimum supply level the output floats.
// - Active-high variant inverts output polarity.
module srs_supervisor
    import srs_pkg::*;
#(
    parameter int HOLD_CYC = SRS_HOLD_CYC,
    parameter int DIP_CYC = SRS_DIP_CYC,
    parameter int BUTTON_CYC = SRS_BUTTON_CYC,
    parameter logic ACTIVE_HIGH = SRS_OUT_ACTIVE_HIGH,
    parameter logic OPEN_DRAIN = SRS_OUT_OPEN_DRAIN,
    parameter logic MANUAL_DETECT = SRS_MANUAL_DETECT
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Supply monitor
    input wire logic supply_low_i,
    input wire logic supply_dead_i,
    // Shared reset line
    input wire logic rst_line_i,
    output logic rst_line_o,
    output logic rst_line_oe_n_o,
    // Status
    output logic reset_active_o
);
    srs_state_t state;
    srs_state_t next_state;
    logic [SRS_CNT_W-1:0] hold_cnt;
    logic [SRS_CNT_W-1:0] next_hold_cnt;
    srs_cause_t cause;
    logic next_active;
    logic next_line;
    logic next_oe_n;
    logic line_low_seen;
    logic next_line_low_seen;

    // ==========================================================
    // Input qualification
    // ==========================================================
    // Supply dip filter: short dips never reach the sequencer
    srs_filter #(.W(SRS_FLT_W), .QUAL_CYC(DIP_CYC)) u_dip (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(supply_low_i),
        .qual_o(cause.supply_low)
    );

    // Manual line debounce; low pulses under BUTTON_CYC are dropped.
    // Sensed only while our drive is released, so our own pull can
    // never pass for a press and retrigger the hold.
    srs_filter #(.W(SRS_FLT_W), .QUAL_CYC(BUTTON_CYC)) u_btn (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(MANUAL_DETECT & ~rst_line_i & rst_line_oe_n_o),
        .qual_o(cause.line_low)
    );

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Our own drive also pulls the line low, so only a qualified low seen
    // while we are released counts as an external request.
    always_comb begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        next_line_low_seen = line_low_seen;
        case (state)
            SRS_ST_LOW: begin
                next_hold_cnt = '0;
                if (!cause.supply_low) begin
                    next_state = SRS_ST_HOLD;
                end
            end
            SRS_ST_HOLD: begin
                if (cause.supply_low) begin
                    next_state = SRS_ST_LOW;
                    next_hold_cnt = '0;
                end else if (hold_cnt >= SRS_CNT_W'(HOLD_CYC - 1)) begin
                    next_state = SRS_ST_RUN;
                    next_hold_cnt = '0;
                end else begin
                    next_hold_cnt = hold_cnt + SRS_CNT_W'(1);
                end
            end
            SRS_ST_RUN: begin
                next_hold_cnt = '0;
                if (cause.supply_low) begin
                    next_state = SRS_ST_LOW;
                    next_line_low_seen = 1'b0;
                end else if (cause.line_low) begin
                    next_line_low_seen = 1'b1;
                end else if (line_low_seen) begin
                    // Release of the debounced line starts the hold
                    next_state = SRS_ST_HOLD;
                    next_line_low_seen = 1'b0;
                end
            end
            default: begin
                next_state = SRS_ST_LOW;
                next_hold_cnt = '0;
                next_line_low_seen = 1'b0;
            end
        endcase
        // Assert on qualified external low too, before the release
        next_active = (next_state != SRS_ST_RUN) | next_line_low_seen;
        // Drive level and enable; float when supply is dead
        next_line = ACTIVE_HIGH ? next_active : ~next_active;
        if (supply_dead_i) begin
            next_oe_n = 1'b1;
        end else if (OPEN_DRAIN) begin
            // The far side holds the line during a press; we let go so
            // that its release stays visible, then drive the hold.
            next_oe_n = (next_state == SRS_ST_RUN);
        end else begin
            next_oe_n = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= SRS_ST_LOW;
            hold_cnt <= '0;
            line_low_seen <= 1'b0;
            reset_active_o <= 1'b1;
            rst_line_o <= ACTIVE_HIGH;
            rst_line_oe_n_o <= 1'b0;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            line_low_seen <= next_line_low_seen;
            reset_active_o <= next_active;
            rst_line_o <= next_line;
            rst_line_oe_n_o <= next_oe_n;
        end
    end
endmodule : srs_supervisor

// *** srs_props.sv ***
// Purpose: Port checker for the supply reset supervisor.
// Assumes: Line polarity and drive kind follow the bound instance.
// Notes:   Margins cover sync and filter latency.
`timescale 1ns/1ns
module srs_props #(
    parameter int HOLD_CYC = 50,
    parameter logic ACTIVE_HIGH = 1'b0,
    parameter logic OPEN_DRAIN = 1'b1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic supply_low_i,
    input wire logic supply_dead_i,
    input wire logic rst_line_i,
    input wire logic rst_line_o,
    input wire logic rst_line_oe_n_o,
    input wire logic reset_active_o
);
    // ==========================================================
    // Age counters
    // ==========================================================
    localparam int DUE = HOLD_CYC + 12;
    logic [7:0] act_cnt, sup_q, ext_q;
    logic [7:0] next_act_cnt, next_sup_q, next_ext_q;
    logic ext_low;
    // Saturate so long idle spans never wrap
    always_comb begin
        ext_low = !rst_line_i && rst_line_oe_n_o;
        next_act_cnt = reset_active_o ? act_cnt + 8'(act_cnt != 8'hFF) : 8'h0;
        next_sup_q = supply_low_i ? 8'h00 : sup_q + 8'(sup_q != 8'hFF);
        next_ext_q = ext_low ? 8'h00 : ext_q + 8'(ext_q != 8'hFF);
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            act_cnt <= 8'h00;
            sup_q <= 8'h00;
            ext_q <= 8'h00;
        end else begin
            act_cnt <= next_act_cnt;
            sup_q <= next_sup_q;
            ext_q <= next_ext_q;
        end
    end
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // During a press the far side holds the line; we take over soon after
    AST_DRIVE: assert property (
        (reset_active_o && !supply_dead_i)[*2] |->
        rst_line_o == ACTIVE_HIGH && (!rst_line_oe_n_o || ext_q < 8'h08))
        else $error("line not driven to reset level");
    AST_OPEN: assert property (
        (!reset_active_o)[*2] |->
        rst_line_o != ACTIVE_HIGH && (rst_line_oe_n_o || !OPEN_DRAIN))
        else $error("line held");
    AST_UNDER: assert property (
        supply_low_i[*8] ##1 supply_low_i[*6] |-> reset_active_o)
        else $error("undervoltage missed");
    AST_QUIET: assert property (
        (!reset_active_o && !supply_low_i && (rst_line_i ^ ACTIVE_HIGH))[*5]
        |=> !reset_active_o) else $error("reset without cause");
    AST_HOLD: assert property (
        $fell(reset_active_o) |-> $past(act_cnt) >= HOLD_CYC)
        else $error("reset pulse too short");
    AST_TIMER: assert property (
        $fell(reset_active_o) |-> $past(sup_q) >= HOLD_CYC)
        else $error("hold timer not cleared");
    AST_DUE: assert property (
        sup_q > DUE && ext_q > DUE |-> !reset_active_o)
        else $error("release late");
    AST_BUTTON: assert property (
        ext_low[*6] |-> ##[0:6] reset_active_o) else $error("press missed");
    AST_FLOAT: assert property (
        supply_dead_i[*3] |-> rst_line_oe_n_o) else $error("no float");
    COV_BROWN: cover property (supply_low_i ##1 $fell(reset_active_o));
    COV_PRESS: cover property (ext_low ##1 reset_active_o);
    COV_DEAD: cover property (supply_dead_i && rst_line_oe_n_o);
endmodule : srs_props
bind srs_supervisor srs_props #(.HOLD_CYC(HOLD_CYC),
    .ACTIVE_HIGH(ACTIVE_HIGH), .OPEN_DRAIN(OPEN_DRAIN)) u_props (
    .clock_i(clock_i), .rst_i(rst_i), .supply_low_i(supply_low_i),
    .supply_dead_i(supply_dead_i), .rst_line_i(rst_line_i),
    .rst_line_o(rst_line_o), .rst_line_oe_n_o(rst_line_oe_n_o),
    .reset_active_o(reset_active_o));

// *** srs_mcu.sv ***
// Purpose: Shared reset line with pull-up, MCU pin and button.
// Assumes: Pull-up wins when nobody drives.
// Notes:   pull_i models the MCU pin or switch contact.
`timescale 1ns/1ns
module srs_mcu (
    // Line drivers
    input wire logic drive_i,
    input wire logic oe_n_i,
    input wire logic pull_i,
    // Resolved level
    output logic line_o
);
    // Wired-AND: either party pulls low
    assign line_o = !pull_i && (oe_n_i || drive_i);
endmodule : srs_mcu

// *** tb_top.sv ***
// Purpose: Directed bench for the supply reset supervisor.
// Assumes: Short counts: hold 50, dip 8, button 4 cycles.
// Notes:   Inputs change 2 ns after the rising edge.
`timescale 1ns/1ns
module tb_top;
    localparam int HOLD = 50;
    logic clock_i = 0, rst_i = 1, low = 0, dead = 0, pull = 0;
    logic line, drive, oe_n, active;
    logic line_hi, drive_hi, oe_n_hi, active_hi;
    int num_errors = 0, check_count = 0, n;
    srs_supervisor #(.HOLD_CYC(HOLD), .DIP_CYC(8), .BUTTON_CYC(4)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .supply_low_i(low),
        .supply_dead_i(dead), .rst_line_i(line), .rst_line_o(drive),
        .rst_line_oe_n_o(oe_n), .reset_active_o(active));
    srs_mcu mcu (.drive_i(drive), .oe_n_i(oe_n), .pull_i(pull),
        .line_o(line));
    // Push-pull active-high variant on a pulled-up line, no manual detect
    srs_supervisor #(.HOLD_CYC(HOLD), .DIP_CYC(8), .BUTTON_CYC(4),
        .ACTIVE_HIGH(1'b1), .OPEN_DRAIN(1'b0), .MANUAL_DETECT(1'b0)) dut_hi (
        .clock_i(clock_i), .rst_i(rst_i), .supply_low_i(low),
        .supply_dead_i(dead), .rst_line_i(line_hi), .rst_line_o(drive_hi),
        .rst_line_oe_n_o(oe_n_hi), .reset_active_o(active_hi));
    srs_mcu mcu_hi (.drive_i(drive_hi), .oe_n_i(oe_n_hi), .pull_i(1'b0),
        .line_o(line_hi));
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    task automatic results;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic e, input logic g);
        check_count++;
        if (e !== g) begin
            num_errors++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clock_i);
        #2;
    endtask : cyc
    // Bounded wait so a stuck reset cannot hang the run
    task automatic rel(input int lo, input int hi);
        n = 0;
        while (active !== 1'b0 && n < 400) begin
            cyc(1);
            n++;
        end
        chk("hold min", 1'b1, n >= lo);
        chk("hold max", 1'b1, n <= hi);
        if (n >= 400) results();
    endtask : rel
    // A dip in mid-hold must restart the whole period
    task automatic t_brown;
        low = 1;
        cyc(14);
        chk("brown line", 1'b0, line);
        chk("hi brown", 1'b1, active_hi);
        chk("hi brown line", 1'b1, line_hi);
        low = 0;
        cyc(20);
        low = 1;
        cyc(14);
        low = 0;
        rel(HOLD, HOLD + 10);
        low = 1;
        cyc(5);
        low = 0;
        cyc(20);
        chk("dip", 1'b0, active);
    endtask : t_brown
    // Bounces shorter than the filter, then a real press
    task automatic t_press;
        repeat (3) begin
            pull = 1;
            cyc(2);
            pull = 0;
            cyc(1);
        end
        chk("bounce", 1'b0, active);
        pull = 1;
        cyc(12);
        chk("press", 1'b1, active);
        pull = 0;
        rel(HOLD, HOLD + 12);
    endtask : t_press
    // Below 1 V the pin floats up to the pull-up
    task automatic t_dead;
        low = 1;
        dead = 1;
        cyc(14);
        chk("float", 1'b1, oe_n);
        chk("float line", 1'b1, line);
        chk("hi float", 1'b1, oe_n_hi);
        dead = 0;
        cyc(4);
        chk("valid", 1'b0, line);
        chk("hi drive", 1'b0, oe_n_hi);
        low = 0;
        rel(HOLD, HOLD + 10);
    endtask : t_dead
    initial begin
        cyc(16);
        rst_i = 0;
        rel(HOLD, HOLD + 10);
        chk("idle oe_n", 1'b1, oe_n);
        chk("hi idle line", 1'b0, line_hi);
        t_brown();
        t_press();
        t_dead();
        results();
    end
endmodule : tb_top
